// ===== pkg/twc_pkg.sv
// Purpose: shared constants and types for the 8-bit waveform timer
// Assumes: 8-bit register port, one core clock
// Notes: mode, action and clock-select codes are the register encodings
package twc_pkg;

  // ***********************************************
  // register map and fields
  // ***********************************************
  localparam logic [7:0] ADDR_CTRL_A = 8'h44;
  localparam logic [7:0] ADDR_CTRL_B = 8'h45;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3; // unimplemented bits 3:2
  localparam logic [7:0] CTRL_B_MASK = 8'h0F; // strobes 7:6 never stored
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam int unsigned ACT_A_LSB = 6;
  localparam int unsigned ACT_B_LSB = 4;
  localparam int unsigned WGM_LSB = 0;
  localparam int unsigned WGM_HI_BIT = 3;
  localparam int unsigned FORCE_A_BIT = 7;
  localparam int unsigned FORCE_B_BIT = 6;
  localparam int unsigned CS_LSB = 0;

  // ***********************************************
  // counter limits and mode codes
  // ***********************************************
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_OCR = 3'h5;
  localparam logic [2:0] MODE_FAST_OCR = 3'h7;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // ***********************************************
  // clock select and prescaler taps
  // ***********************************************
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int unsigned PRESC_W = 10;
  localparam logic [9:0] TAP_DIV8 = 10'h007;
  localparam logic [9:0] TAP_DIV64 = 10'h03F;
  localparam logic [9:0] TAP_DIV256 = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;
  localparam logic [9:0] PRESC_ONE = 10'h001;

  // ***********************************************
  // carriers and state
  // ***********************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } twc_io_req_s;

  typedef struct packed {
    logic level;
    logic oe;
  } twc_pin_s;

  typedef enum logic {TWC_UP, TWC_DOWN} twc_dir_e;

endpackage

// ===== rtl/twc_prescaler.sv
// Purpose: timer tick enable from prescaler, external pin or oscillator
// Assumes: pins are asynchronous to core_clk
// Notes: output is a one-cycle enable, never a clock
module twc_prescaler #(
  parameter bit ASYNC_SRC = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [2:0] clock_source_select,
  input wire logic external_count_pin,
  input wire logic osc_clk_pin,
  output logic timer_tick_enable
);
  import twc_pkg::*;

  logic [2:0] ext_sync_r;
  logic [2:0] osc_sync_r;
  logic ext_level_r;
  logic osc_level_r;
  logic [PRESC_W-1:0] div_r;
  logic tick_nxt;

  // three-stage synchronisers, level accepted once stages 2 and 3 agree
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_sync_r <= 3'h0;
      osc_sync_r <= 3'h0;
      ext_level_r <= 1'b0;
      osc_level_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], external_count_pin};
      osc_sync_r <= {osc_sync_r[1:0], osc_clk_pin};
      if (ext_sync_r[2] == ext_sync_r[1]) ext_level_r <= ext_sync_r[2];
      if (osc_sync_r[2] == osc_sync_r[1]) osc_level_r <= osc_sync_r[2];
    end
  end

  // edges of the filtered levels
  wire ext_agree_w = ext_sync_r[2] == ext_sync_r[1];
  wire ext_rise_w = ext_agree_w & ext_sync_r[2] & ~ext_level_r;
  wire ext_fall_w = ext_agree_w & ~ext_sync_r[2] & ext_level_r;
  wire osc_rise_w = (osc_sync_r[2] == osc_sync_r[1]) & osc_sync_r[2] & ~osc_level_r;
  wire base_en_w = ASYNC_SRC ? osc_rise_w : 1'b1;

  // free-running prescaler; shared taps keep all divisions phase locked
  always_ff @(posedge core_clk) begin
    if (sys_rst) div_r <= '0;
    else if (base_en_w) div_r <= div_r + PRESC_ONE;
  end

  always_comb begin
    unique case (clock_source_select)
      CS_STOP: tick_nxt = 1'b0;
      CS_DIV1: tick_nxt = base_en_w;
      CS_DIV8: tick_nxt = base_en_w & ((div_r & TAP_DIV8) == TAP_DIV8);
      CS_DIV64: tick_nxt = base_en_w & ((div_r & TAP_DIV64) == TAP_DIV64);
      CS_DIV256: tick_nxt = base_en_w & ((div_r & TAP_DIV256) == TAP_DIV256);
      CS_DIV1024: tick_nxt = base_en_w & (div_r == TAP_DIV1024);
      CS_EXT_FALL: tick_nxt = ext_fall_w;
      CS_EXT_RISE: tick_nxt = ext_rise_w;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) timer_tick_enable <= 1'b0;
    else timer_tick_enable <= tick_nxt;
  end

  AST_TICK_PULSE:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (timer_tick_enable && clock_source_select == CS_DIV8
       && $stable(clock_source_select)) |=> !timer_tick_enable [*7])
    else $error("prescaled tick not a single-cycle enable");

  AST_TICK_STOP:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (clock_source_select == CS_STOP) [*2] |-> !timer_tick_enable)
    else $error("tick while clock source stopped");

endmodule

// ===== rtl/twc_timer.sv
// Purpose: 8-bit timer with two compare channels and waveform outputs
// Assumes: compare values come from their registers outside, same clock
// Notes: flags leave as one-cycle pulses to the flag register
//
// How it works
// - everything runs on core_clk; the timer tick is only an enable
// - asynchronous instances take counter timing from the oscillator pin
// - nonzero action overrides the pin, except PWM toggle on B or on A without mode high bit; driver on only with direction set
// - non-PWM channel A: off, toggle, clear or set on match
// - non-PWM channel B uses the same action encoding as channel A
// - fast PWM channel A: clear on match set at bottom, or inverse
// - PWM channel A toggle action works only with mode high bit set
// - fast PWM channel B as A; toggle code reserved in PWM modes
// - phase-correct channel A: clear up-match, set down-match, or inverse
// - phase-correct channel B behaves like channel A
// - fast PWM, A compare equal TOP: match ignored, action at bottom
// - phase-correct, compare equal TOP: match ignored, action at TOP
// - fast PWM, B compare equal TOP: match ignored, action at bottom
// - mode select decodes counter sequence and TOP source
// - compare buffers update per mode; overflow at MAX, BOTTOM or TOP
// - clear-on-match and fast PWM with A as TOP clear on A match
// - force strobe applies action in non-PWM modes, no flag, reads zero
// - clock source: stop, divide 1/8/64/256/1024, pin falling or rising
module twc_timer #(
  parameter bit ASYNC_SRC = 1'b0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire twc_pkg::twc_io_req_s io_req,
  output logic [7:0] io_rdata,
  input wire logic [7:0] chan_a_compare_value,
  input wire logic [7:0] chan_b_compare_value,
  input wire logic pin_dir_a,
  input wire logic pin_dir_b,
  input wire logic external_count_pin,
  input wire logic osc_clk_pin,
  output logic [7:0] counter_value,
  output logic chan_a_match_flag,
  output logic chan_b_match_flag,
  output logic overflow_flag,
  output twc_pkg::twc_pin_s chan_a_waveform_out,
  output twc_pkg::twc_pin_s chan_b_waveform_out
);
  import twc_pkg::*;

  // ***********************************************
  // waveform step
  // ***********************************************

  // next waveform level for one channel in the current mode
  function automatic logic wave_step(
    input logic cur,
    input logic [1:0] act,
    input logic tog_ok,
    input logic hit,
    input logic up,
    input logic top_ev,
    input logic cmp_top,
    input logic nonpwm,
    input logic fast,
    input logic pc
  );
    logic v;
    v = cur;
    if (nonpwm) begin
      if (hit) begin
        unique case (act)
          ACT_OFF: v = cur;
          ACT_TOGGLE: v = ~cur;
          ACT_CLEAR: v = 1'b0;
          ACT_SET: v = 1'b1;
        endcase
      end
    end else if (fast || pc) begin
      if (act == ACT_TOGGLE) begin
        if (tog_ok && hit) v = ~cur;
      end else if (act[1]) begin
        if (fast && top_ev) begin
          // counter leaves TOP for BOTTOM: set non-inverting, clear inverting
          v = (act == ACT_CLEAR);
        end else if (pc && cmp_top) begin
          if (top_ev) v = (act == ACT_CLEAR);
        end else if (hit && !cmp_top) begin
          v = up ? (act == ACT_SET) : (act == ACT_CLEAR);
        end
      end
    end
    return v;
  endfunction

  // ***********************************************
  // state
  // ***********************************************
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] ocr_a_r;
  logic [7:0] ocr_b_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  twc_dir_e dir_r;
  twc_dir_e dir_nxt;
  logic wave_a_r;
  logic wave_b_r;
  logic tick;

  twc_prescaler #(
    .ASYNC_SRC(ASYNC_SRC)
  ) u_presc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clock_source_select(ctrl_b_r[CS_LSB +: 3]),
    .external_count_pin(external_count_pin),
    .osc_clk_pin(osc_clk_pin),
    .timer_tick_enable(tick)
  );

  // ***********************************************
  // control decode
  // ***********************************************

  // fields of the control registers
  wire [1:0] act_a_w = ctrl_a_r[ACT_A_LSB +: 2];
  wire [1:0] act_b_w = ctrl_a_r[ACT_B_LSB +: 2];
  wire wgm_hi_w = ctrl_b_r[WGM_HI_BIT];
  wire [2:0] mode_w = {wgm_hi_w, ctrl_a_r[WGM_LSB +: 2]};

  wire nonpwm_w = (mode_w == MODE_NORMAL) || (mode_w == MODE_CTC);
  wire fast_w = (mode_w == MODE_FAST_MAX) || (mode_w == MODE_FAST_OCR);
  wire pc_w = (mode_w == MODE_PC_MAX) || (mode_w == MODE_PC_OCR);
  wire rsvd_w = !(nonpwm_w || fast_w || pc_w);
  wire top_ocr_w = (mode_w == MODE_CTC) || (mode_w == MODE_PC_OCR)
                   || (mode_w == MODE_FAST_OCR);
  wire [7:0] top_w = top_ocr_w ? ocr_a_r : CNT_MAX;

  // counter position
  wire at_top_w = cnt_r == top_w;
  wire at_bot_w = cnt_r == CNT_BOTTOM;
  wire at_max_w = cnt_r == CNT_MAX;
  wire up_w = dir_r == TWC_UP;
  // reserved modes hold the counter still
  wire run_w = tick && !rsvd_w;
  wire top_ev_w = run_w && at_top_w;

  // compare matches on the current count
  wire match_a_w = run_w && (cnt_r == ocr_a_r);
  wire match_b_w = run_w && (cnt_r == ocr_b_r);
  wire cmp_a_top_w = ocr_a_r == top_w;
  wire cmp_b_top_w = ocr_b_r == top_w;

  wire ovf_w = run_w && ((mode_w == MODE_FAST_OCR) ? at_top_w :
                         pc_w ? at_bot_w : at_max_w);

  wire ocr_load_w = nonpwm_w || rsvd_w || top_ev_w;

  // ***********************************************
  // register port decode
  // ***********************************************
  wire wr_a_w = io_req.wr && (io_req.addr == ADDR_CTRL_A);
  wire wr_b_w = io_req.wr && (io_req.addr == ADDR_CTRL_B);
  // force strobes act only in non-PWM modes
  wire force_a_w = wr_b_w && io_req.wdata[FORCE_A_BIT] && nonpwm_w;
  wire force_b_w = wr_b_w && io_req.wdata[FORCE_B_BIT] && nonpwm_w;
  wire [7:0] rd_mux_w = (io_req.addr == ADDR_CTRL_A) ? ctrl_a_r :
                        (io_req.addr == ADDR_CTRL_B) ? ctrl_b_r : READ_IDLE;

  // control registers store only implemented bits
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_a_r <= CTRL_RESET;
      ctrl_b_r <= CTRL_RESET;
    end else begin
      if (wr_a_w) ctrl_a_r <= io_req.wdata & CTRL_A_MASK;
      if (wr_b_w) ctrl_b_r <= io_req.wdata & CTRL_B_MASK;
    end
  end

  // read data one cycle after the read request
  always_ff @(posedge core_clk) begin
    if (sys_rst) io_rdata <= READ_IDLE;
    else io_rdata <= io_req.rd ? rd_mux_w : READ_IDLE;
  end

  // ***********************************************
  // compare buffers
  // ***********************************************

  // double buffering in PWM modes avoids glitched periods
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ocr_a_r <= CNT_BOTTOM;
      ocr_b_r <= CNT_BOTTOM;
    end else if (ocr_load_w) begin
      ocr_a_r <= chan_a_compare_value;
      ocr_b_r <= chan_b_compare_value;
    end
  end

  // ***********************************************
  // counter
  // ***********************************************

  // count sequence; clear at TOP in single-slope modes
  always_comb begin
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    if (run_w) begin
      if (pc_w) begin
        if (up_w) begin
          if (at_top_w) begin
            // a TOP of zero would otherwise wrap to MAX
            cnt_nxt = at_bot_w ? cnt_r : cnt_r - CNT_STEP;
            dir_nxt = TWC_DOWN;
          end else begin
            cnt_nxt = cnt_r + CNT_STEP;
          end
        end else if (at_bot_w) begin
          cnt_nxt = cnt_r + CNT_STEP;
          dir_nxt = TWC_UP;
        end else begin
          cnt_nxt = cnt_r - CNT_STEP;
        end
      end else if (mode_w == MODE_NORMAL) begin
        cnt_nxt = cnt_r + CNT_STEP;
        dir_nxt = TWC_UP;
      end else begin
        cnt_nxt = at_top_w ? CNT_BOTTOM : cnt_r + CNT_STEP;
        dir_nxt = TWC_UP;
      end
    end
  end

  // counter advances only on the tick enable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r <= CNT_BOTTOM;
      dir_r <= TWC_UP;
    end else begin
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
    end
  end

  // ***********************************************
  // waveform generators
  // ***********************************************

  wire wave_a_nxt = wave_step(wave_a_r, act_a_w, wgm_hi_w, match_a_w | force_a_w,
                              up_w, top_ev_w, cmp_a_top_w, nonpwm_w, fast_w, pc_w);
  // channel B, toggle never allowed in PWM
  wire wave_b_nxt = wave_step(wave_b_r, act_b_w, 1'b0, match_b_w | force_b_w,
                              up_w, top_ev_w, cmp_b_top_w, nonpwm_w, fast_w, pc_w);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      wave_a_r <= wave_a_nxt;
      wave_b_r <= wave_b_nxt;
    end
  end

  // override when any action bit set; PWM toggle code disconnects B, and A unless mode high bit set
  wire ovr_a_w = (fast_w || pc_w) ? (act_a_w[1] || (act_a_w == ACT_TOGGLE && wgm_hi_w))
                                  : (act_a_w != ACT_OFF);
  wire ovr_b_w = (fast_w || pc_w) ? act_b_w[1] : (act_b_w != ACT_OFF);

  // pin driver gated by its direction bit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chan_a_waveform_out <= '0;
      chan_b_waveform_out <= '0;
    end else begin
      chan_a_waveform_out.level <= wave_a_r;
      chan_a_waveform_out.oe <= ovr_a_w && pin_dir_a;
      chan_b_waveform_out.level <= wave_b_r;
      chan_b_waveform_out.oe <= ovr_b_w && pin_dir_b;
    end
  end

  // ***********************************************
  // flags and count out
  // ***********************************************

  // flags from real matches only, never from a force strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chan_a_match_flag <= 1'b0;
      chan_b_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
      counter_value <= CNT_BOTTOM;
    end else begin
      chan_a_match_flag <= match_a_w;
      chan_b_match_flag <= match_b_w;
      overflow_flag <= ovf_w;
      counter_value <= cnt_nxt;
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  AST_PIN_RELEASE:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (act_a_w == ACT_OFF || !pin_dir_a) |=> !chan_a_waveform_out.oe)
    else $error("channel A drives pin while disconnected");

  AST_NONPWM_TOGGLE:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (nonpwm_w && match_a_w && act_a_w == ACT_TOGGLE)
      |=> ##1 chan_a_waveform_out.level != $past(chan_a_waveform_out.level))
    else $error("channel A did not toggle on match");

  AST_NONPWM_CLEAR_B:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (nonpwm_w && match_b_w && act_b_w == ACT_CLEAR) |=> ##1 !chan_b_waveform_out.level)
    else $error("channel B not cleared on match");

  AST_FAST_BOTTOM_SET:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (fast_w && top_ev_w && act_a_w == ACT_CLEAR) |=> wave_a_r)
    else $error("fast PWM channel A not set at bottom");

  AST_PC_UP_CLEAR:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (pc_w && match_a_w && up_w && !cmp_a_top_w && act_a_w == ACT_CLEAR) |=> !wave_a_r)
    else $error("phase-correct channel A not cleared on up match");

  AST_PC_DOWN_CLEAR_B:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (pc_w && match_b_w && !up_w && !cmp_b_top_w && act_b_w == ACT_SET) |=> !wave_b_r)
    else $error("phase-correct channel B not cleared on down match");

  AST_NORMAL_WRAP:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (mode_w == MODE_NORMAL && run_w && at_max_w)
      |=> overflow_flag && counter_value == CNT_BOTTOM)
    else $error("normal mode wrap without overflow");

  AST_CTC_CLEAR:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (mode_w == MODE_CTC && match_a_w) |=> chan_a_match_flag && cnt_r == CNT_BOTTOM)
    else $error("clear-on-match did not clear counter");

  AST_FORCE_QUIET:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (force_a_w && !run_w) |=> !chan_a_match_flag && $stable(cnt_r))
    else $error("force strobe raised flag or moved counter");

  AST_RSVD_BITS:
    assert property (@(posedge core_clk) disable iff (sys_rst)
      (io_req.rd && io_req.addr == ADDR_CTRL_B) |=> io_rdata[7:4] == 4'h0)
    else $error("unimplemented control bits read nonzero");

endmodule

// ===== sim/twc_timer_bench.sv
// Purpose: self-checking bench for the 8-bit waveform timer
// Assumes: inputs change at the falling edge of core_clk
// Notes: pulses and levels are counted over whole periods, so phase never matters
module twc_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import twc_pkg::*;

  `define CHK(nm, exp, got) \
    begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s exp=%0h got=%0h", nm, exp, got); end end

  // ***********************************************
  // signals and device
  // ***********************************************
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  twc_io_req_s io_req = '0;
  logic [7:0] io_rdata, counter_value, rd_val, max_cnt;
  logic [7:0] ocr_a = 8'h00;
  logic [7:0] ocr_b = 8'h00;
  logic dir_a = 1'b1;
  logic dir_b = 1'b1;
  logic ext_pin = 1'b0;
  logic fa_w, fb_w, ov_w;
  twc_pin_s wa, wb;
  int err_count = 0;
  int cmp_count = 0;
  int n_fa, n_fb, n_ov, hi_a, hi_b, tg_a;

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // oscillator pin tied: this instance runs from core_clk only
  twc_timer dut (.core_clk(core_clk), .sys_rst(sys_rst), .io_req(io_req),
    .io_rdata(io_rdata), .chan_a_compare_value(ocr_a), .chan_b_compare_value(ocr_b),
    .pin_dir_a(dir_a), .pin_dir_b(dir_b), .external_count_pin(ext_pin),
    .osc_clk_pin(1'b0), .counter_value(counter_value), .chan_a_match_flag(fa_w),
    .chan_b_match_flag(fb_w), .overflow_flag(ov_w), .chan_a_waveform_out(wa),
    .chan_b_waveform_out(wb));

  // ***********************************************
  // shared tasks
  // ***********************************************
  // one-cycle strobes, so a write never merges with the next one
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge core_clk);
    io_req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(negedge core_clk);
    io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge core_clk);
    io_req.rd <= 1'b0;
    rd_val = io_rdata;
  endtask

  // fresh reset before each setup, so no state leaks between tests
  task automatic cfg(input logic [2:0] md, input logic [1:0] aa, input logic [1:0] ab,
                     input logic [2:0] cs, input logic [7:0] oa, input logic [7:0] ob);
    @(negedge core_clk);
    sys_rst <= 1'b1;
    ocr_a <= oa;
    ocr_b <= ob;
    repeat (4) @(negedge core_clk);
    sys_rst <= 1'b0;
    reg_wr(ADDR_CTRL_A, {aa, ab, 2'b00, md[1:0]});
    reg_wr(ADDR_CTRL_B, {4'h0, md[2], cs});
  endtask

  // pulse, level-high and toggle counts over n cycles
  task automatic measure(input int settle, input int n);
    logic pa;
    repeat (settle) @(negedge core_clk);
    {n_fa, n_fb, n_ov, hi_a, hi_b, tg_a} = '0;
    max_cnt = 8'h00;
    pa = wa.level;
    repeat (n) begin
      @(negedge core_clk);
      n_fa += int'(fa_w === 1'b1);
      n_fb += int'(fb_w === 1'b1);
      n_ov += int'(ov_w === 1'b1);
      hi_a += int'(wa.level === 1'b1);
      hi_b += int'(wb.level === 1'b1);
      tg_a += int'(wa.level !== pa);
      pa = wa.level;
      if (counter_value > max_cnt) max_cnt = counter_value;
    end
  endtask

  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_regs;
    reg_rd(ADDR_CTRL_A);
    `CHK("ctrl_a reset", CTRL_RESET, rd_val)
    reg_rd(ADDR_CTRL_B);
    `CHK("ctrl_b reset", CTRL_RESET, rd_val)
    reg_wr(ADDR_CTRL_A, 8'hFF);
    reg_rd(ADDR_CTRL_A);
    `CHK("ctrl_a bits", 8'hF3, rd_val)
    reg_wr(ADDR_CTRL_B, 8'hF8);
    reg_rd(ADDR_CTRL_B);
    `CHK("ctrl_b bits", 8'h08, rd_val)
    reg_wr(8'h46, 8'h5A);
    reg_rd(8'h46);
    `CHK("unmapped read", 8'h00, rd_val)
    $display("test regs done");
  endtask

  task automatic t_ctc;
    cfg(MODE_CTC, ACT_TOGGLE, ACT_TOGGLE, CS_DIV1, 8'h02, 8'h01);
    measure(20, 30);
    `CHK("ctc flag a", 10, n_fa)
    `CHK("ctc flag b", 10, n_fb)
    `CHK("ctc toggles a", 10, tg_a)
    `CHK("ctc max count", 8'h02, max_cnt)
    `CHK("ctc overflow", 0, n_ov)
    `CHK("oe with dir", 1'b1, wa.oe)
    dir_a <= 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK("oe without dir", 1'b0, wa.oe)
    dir_a <= 1'b1;
    $display("test ctc done");
  endtask

  task automatic t_normal;
    cfg(MODE_NORMAL, ACT_TOGGLE, ACT_SET, CS_DIV1, 8'h40, 8'h80);
    measure(20, 512);
    `CHK("normal flag a", 2, n_fa)
    `CHK("normal toggles a", 2, tg_a)
    `CHK("normal flag b", 2, n_fb)
    `CHK("normal set b", 1'b1, wb.level)
    `CHK("normal overflow", 2, n_ov)
    `CHK("normal max count", 8'hFF, max_cnt)
    $display("test normal done");
  endtask

  task automatic t_force;
    cfg(MODE_NORMAL, ACT_SET, ACT_TOGGLE, CS_STOP, 8'h10, 8'h10);
    reg_wr(ADDR_CTRL_B, 8'hC0);
    measure(0, 4);
    `CHK("force set a", 1'b1, wa.level)
    `CHK("force toggle b", 1'b1, wb.level)
    `CHK("force no flag", 0, n_fa + n_fb)
    `CHK("stopped count", 8'h00, counter_value)
    reg_rd(ADDR_CTRL_B);
    `CHK("strobes read zero", 8'h00, rd_val)
    // forced-high b must fall again on a real match with the clear action
    reg_wr(ADDR_CTRL_A, {ACT_SET, ACT_CLEAR, 4'h0});
    reg_wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
    measure(0, 256);
    `CHK("clear b on match", 1'b0, wb.level)
    `CHK("match b once", 1, n_fb)
    $display("test force done");
  endtask

  task automatic t_pwm;
    cfg(MODE_FAST_MAX, ACT_CLEAR, ACT_SET, CS_DIV1, 8'h40, 8'h80);
    measure(600, 512);
    `CHK("fast high a", 130, hi_a)
    `CHK("fast high b", 254, hi_b)
    `CHK("fast overflow", 2, n_ov)
    `CHK("oe b driven", 1'b1, wb.oe)
    cfg(MODE_FAST_MAX, ACT_TOGGLE, ACT_TOGGLE, CS_DIV1, 8'h40, 8'h00);
    measure(20, 512);
    `CHK("toggle without high bit", 0, tg_a)
    `CHK("toggle a released", 1'b0, wa.oe)
    `CHK("reserved b released", 1'b0, wb.oe)
    cfg(MODE_PC_MAX, ACT_CLEAR, ACT_CLEAR, CS_DIV1, 8'h40, 8'hFF);
    measure(600, 1020);
    `CHK("pc high a", 256, hi_a)
    `CHK("pc top b", 1020, hi_b)
    `CHK("pc overflow", 2, n_ov)
    $display("test pwm done");
  endtask

  task automatic t_top;
    cfg(MODE_FAST_OCR, ACT_TOGGLE, ACT_CLEAR, CS_DIV1, 8'h20, 8'h20);
    measure(100, 330);
    `CHK("top toggles a", 10, tg_a)
    `CHK("top flag a", 10, n_fa)
    `CHK("top overflow", 10, n_ov)
    `CHK("top max count", 8'h20, max_cnt)
    `CHK("top b constant", 330, hi_b)
    cfg(MODE_FAST_OCR, ACT_CLEAR, ACT_OFF, CS_DIV1, 8'h20, 8'h00);
    measure(100, 330);
    `CHK("top a constant", 330, hi_a)
    // dual slope with TOP from compare a: period 64, b inverting
    cfg(MODE_PC_OCR, ACT_CLEAR, ACT_SET, CS_DIV1, 8'h20, 8'h10);
    measure(100, 640);
    `CHK("pc ocr top a", 640, hi_a)
    `CHK("pc ocr high b", 320, hi_b)
    `CHK("pc ocr overflow", 10, n_ov)
    `CHK("pc ocr max count", 8'h20, max_cnt)
    $display("test top done");
  endtask

  task automatic t_clk;
    logic [2:0] srcs [2] = '{CS_EXT_FALL, CS_EXT_RISE};
    cfg(MODE_NORMAL, ACT_OFF, ACT_OFF, CS_DIV8, 8'h00, 8'h00);
    measure(20, 4096);
    `CHK("div8 overflow", 2, n_ov)
    foreach (srcs[i]) begin
      cfg(MODE_NORMAL, ACT_OFF, ACT_OFF, srcs[i], 8'h00, 8'h00);
      repeat (10) begin
        repeat (4) @(negedge core_clk);
        ext_pin <= 1'b1;
        repeat (4) @(negedge core_clk);
        ext_pin <= 1'b0;
      end
      repeat (8) @(negedge core_clk);
      `CHK("pin edges", 8'h0A, counter_value)
    end
    // compare of zero in clear-on-match flags every tick, so flags count ticks
    cfg(MODE_CTC, ACT_OFF, ACT_OFF, CS_DIV64, 8'h00, 8'h00);
    measure(0, 640);
    `CHK("div64 ticks", 10, n_fa)
    cfg(MODE_CTC, ACT_OFF, ACT_OFF, CS_DIV256, 8'h00, 8'h00);
    measure(0, 1280);
    `CHK("div256 ticks", 5, n_fa)
    cfg(MODE_CTC, ACT_OFF, ACT_OFF, CS_DIV1024, 8'h00, 8'h00);
    measure(0, 2048);
    `CHK("div1024 ticks", 2, n_fa)
    // reserved mode keeps the counter frozen
    cfg(3'h4, ACT_OFF, ACT_OFF, CS_DIV1, 8'h00, 8'h00);
    measure(10, 50);
    `CHK("reserved frozen", 8'h00, max_cnt)
    $display("test clock done");
  endtask

  // ***********************************************
  // run control
  // ***********************************************
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // about 14k cycles expected; 40k cycles cuts a hang
  initial begin
    #200us;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_ctc();
    t_normal();
    t_force();
    t_pwm();
    t_top();
    t_clk();
    wrap_up();
  end
endmodule
